// File: fcdma_map.vh
// Register map, field positions, reset values and codes of the four-channel transfer unit.
// Assumes inclusion by fcdma_controller.v only; holds definitions and nothing else.
`ifndef FCDMA_MAP_VH
`define FCDMA_MAP_VH

// ==========================================================
// Register offsets within one sub-channel window, and the global register address
`define FCDMA_FIELD_MAR 2'h0
`define FCDMA_FIELD_IOAR 2'h1
`define FCDMA_FIELD_COUNT 2'h2
`define FCDMA_FIELD_CTRL 2'h3
`define FCDMA_GLOBAL_ADDR 7'h40

// ==========================================================
// Control register fields, control reset value and the global stop bit
`define FCDMA_CTRL_ENABLE 7
`define FCDMA_CTRL_WORD 6
`define FCDMA_CTRL_DOWN 5
`define FCDMA_CTRL_HOLD 4
`define FCDMA_CTRL_FIX_DST 3
`define FCDMA_CTRL_RESET 8'h00
`define FCDMA_GLOBAL_STOP 0

// ==========================================================
// Short address modes, held in control bits 4:3
`define FCDMA_MODE_IO 2'h0
`define FCDMA_MODE_IDLE 2'h1
`define FCDMA_MODE_REPEAT 2'h2

// ==========================================================
// Activation select, control bits 2:0, short address mode
`define FCDMA_SRC_TMR2 3'h2
`define FCDMA_SRC_TX 3'h3
`define FCDMA_SRC_RX 3'h4
`define FCDMA_SRC_ADC 3'h5
`define FCDMA_SRC_EXT 3'h6

// Activation select of sub-channel B in full address mode
`define FCDMA_FULL_AUTO_BURST 3'h0
`define FCDMA_FULL_AUTO_STEAL 3'h1
`define FCDMA_FULL_EXT_NORMAL 3'h2
`define FCDMA_FULL_EXT_BLOCK 3'h3
`define FCDMA_FULL_TMR2_BLOCK 3'h6

// ==========================================================
// Fixed values
`define FCDMA_IO_PAGE 16'hffff
`define FCDMA_COUNT_ONE 16'h0001
`define FCDMA_BYTE_ONE 8'h01

`endif

// File: fcdma_controller.v
// Four-channel direct transfer unit with Avalon-MM register slave and a simple memory master.
// Assumes one clock, an arbiter that holds bus_grant while bus_request stays high, and peripheral
// event inputs that are one-cycle pulses from the same clock.
//
// Summary of operation
// - Short mode pairs 8-bit with 24-bit address.
// - Short mode gives four independent sub-channels.
// - Full mode: two channels, 24-bit both sides.
// - Short sub-channel runs I/O, idle or repeat.
// - Full channel runs normal or block mode.
// - 24-bit addresses; byte or word unit.
// - I/O mode steps memory address by 1/2.
// - Idle mode keeps memory address fixed.
// - I/O and idle count 1 to 65536.
// - Repeat restores address and count, never stops.
// - Auto-request latches and runs all transfers.
// - Auto-request chooses burst or cycle steal.
// - External normal mode moves one per request.
// - Block mode moves one block per request.
// - Block mode revisits a fixed source or destination.
// - Block mode triggers: timers, external, converter.
// - Timer/transmit triggers read memory, write peripheral.
// - Receive/converter triggers read peripheral, write memory.
// - One transfer-end output per channel pair.
// - Sub-channel A ignores external request.
// - Whole unit can be stopped by software.
// - Both mode-select bits set gives full mode.
// - Repeat: upper byte counts, reloads from lower.
// - I/O and idle: 16-bit count, stop at zero.
`timescale 1ns/1ps
`include "fcdma_map.vh"

module fcdma_controller (
  input wire clock,
  input wire reset,
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [2:0] timer_match_a,
  input wire serial_tx_empty,
  input wire serial_rx_full,
  input wire adc_conversion_end,
  input wire [1:0] ext_xfer_request_n,
  output reg [1:0] xfer_end_n,
  output reg bus_request,
  input wire bus_grant,
  output reg [23:0] mem_address,
  output reg mem_read,
  output reg mem_write,
  output reg mem_word,
  output reg [15:0] mem_write_data,
  input wire [15:0] mem_read_data,
  input wire mem_done
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_REQ = 3'h1;
  localparam [2:0] S_READ = 3'h2;
  localparam [2:0] S_WRITE = 3'h3;
  localparam [2:0] S_NEXT = 3'h4;

  reg [23:0] mar [0:3];
  reg [23:0] mar_init [0:3];
  reg [7:0] ioar [0:3];
  reg [15:0] count [0:3];
  reg [7:0] ctrl [0:3];
  reg stop;
  reg [3:0] pending;
  reg [2:0] state;
  reg [1:0] cur;
  reg cont;
  reg ack;
  reg [1:0] ext_s1;
  reg [1:0] ext_s2;
  reg [1:0] ext_s3;
  reg [1:0] ext_level;
  reg [1:0] ext_prev;
  integer k;
  integer j;
  integer m;

  // ==========================================================
  // Helper functions

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge = (old & ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}) |
              (wd & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
    end
  endfunction

  function [23:0] step_addr;
    input [23:0] a;
    input down;
    input word;
    begin
      step_addr = down ? a - {22'h0, word, ~word} : a + {22'h0, word, ~word};
    end
  endfunction

  // ==========================================================
  // External request synchroniser and edge detect

  wire [1:0] ext_agree = ~(ext_s2 ^ ext_s3);
  wire [1:0] ext_event = ext_level & ~ext_prev;

  always @(posedge clock) begin
    if (reset) begin
      ext_s1 <= 2'h3;
      ext_s2 <= 2'h3;
      ext_s3 <= 2'h3;
      ext_level <= 2'h0;
      ext_prev <= 2'h0;
    end else begin
      ext_s1 <= ext_xfer_request_n;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      ext_level <= (ext_agree & ~ext_s2) | (~ext_agree & ext_level);
      ext_prev <= ext_level;
    end
  end

  // ==========================================================
  // Pair mode and activation decode

  wire [1:0] pair_full;
  assign pair_full[0] = ctrl[0][2] & ctrl[0][1];
  assign pair_full[1] = ctrl[2][2] & ctrl[2][1];

  reg [3:0] set_pend;
  reg [2:0] sel;
  reg hit;
  always @* begin
    set_pend = 4'h0;
    sel = 3'h0;
    hit = 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      hit = 1'b0;
      if (pair_full[k / 2]) begin
        sel = ctrl[k | 1][2:0];
        if (k % 2 == 0) begin
          if (sel == `FCDMA_FULL_AUTO_BURST || sel == `FCDMA_FULL_AUTO_STEAL)
            hit = 1'b1;
          else if (sel == `FCDMA_FULL_EXT_NORMAL || sel == `FCDMA_FULL_EXT_BLOCK)
            hit = ext_event[k / 2];
          else if (sel <= `FCDMA_FULL_TMR2_BLOCK)
            hit = timer_match_a[sel[1:0]];
          else
            hit = adc_conversion_end;
        end
      end else begin
        sel = ctrl[k][2:0];
        case (sel)
          3'h0, 3'h1, `FCDMA_SRC_TMR2: hit = timer_match_a[sel[1:0]];
          `FCDMA_SRC_TX: hit = serial_tx_empty;
          `FCDMA_SRC_RX: hit = serial_rx_full;
          `FCDMA_SRC_ADC: hit = adc_conversion_end;
          `FCDMA_SRC_EXT: hit = (k % 2 == 1) & ext_event[k / 2];
          default: hit = 1'b0;
        endcase
      end
      set_pend[k] = hit & ctrl[k][`FCDMA_CTRL_ENABLE] & ~stop;
    end
  end

  // ==========================================================
  // Channel selection, lowest index first

  reg [3:0] elig;
  reg [1:0] pick;
  always @* begin
    pick = 2'h0;
    for (j = 0; j < 4; j = j + 1)
      elig[j] = pending[j] & ctrl[j][`FCDMA_CTRL_ENABLE] & ~(pair_full[j / 2] & (j % 2 == 1));
    for (j = 3; j >= 0; j = j - 1)
      if (elig[j])
        pick = j[1:0];
  end

  // Requests of a disabled sub-channel are dropped so they cannot fire on a later enable.
  wire [3:0] en_mask = {ctrl[3][7], ctrl[2][7], ctrl[1][7], ctrl[0][7]};

  wire start = (state == S_IDLE) & ~stop & (|elig);

  // ==========================================================
  // Address and count view of the channel in service

  wire [1:0] ia = {cur[1], 1'b0};
  wire [1:0] ib = {cur[1], 1'b1};
  wire cur_full = pair_full[cur[1]];
  wire word = ctrl[cur][`FCDMA_CTRL_WORD];
  wire [2:0] ssel = ctrl[cur][2:0];
  wire [2:0] fsel = ctrl[ib][2:0];
  wire [1:0] mode = ctrl[cur][4:3];
  wire [15:0] cnt = count[cur];
  wire [15:0] cntb = count[ib];
  wire io_src = (ssel == `FCDMA_SRC_RX) | (ssel == `FCDMA_SRC_ADC);
  wire [23:0] io_a = {`FCDMA_IO_PAGE, ioar[cur]};
  wire [23:0] src_addr = cur_full ? mar[ia] : (io_src ? io_a : mar[cur]);
  wire [23:0] dst_addr = cur_full ? mar[ib] : (io_src ? mar[cur] : io_a);
  wire block = cur_full & (fsel >= `FCDMA_FULL_EXT_BLOCK);
  wire auto_burst = cur_full & (fsel == `FCDMA_FULL_AUTO_BURST);
  wire blk_end = cntb[15:8] == `FCDMA_BYTE_ONE;
  wire last = cur_full ? ((cnt == `FCDMA_COUNT_ONE) & (~block | blk_end)) :
              (mode == `FCDMA_MODE_REPEAT) ? (cnt[15:8] == `FCDMA_BYTE_ONE) : (cnt == `FCDMA_COUNT_ONE);

  // ==========================================================
  // Avalon slave handshake, one wait state per access

  wire access = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack;
  wire wr_en = avs_write & ack & ~avs_address[6];
  wire [1:0] ws = avs_address[5:4];
  wire [1:0] wf = avs_address[3:2];
  wire [31:0] mar_merged = merge({8'h0, mar[ws]}, avs_writedata, avs_byteenable);
  wire [31:0] count_merged = merge({16'h0, count[ws]}, avs_writedata, avs_byteenable);

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    if (~avs_address[6]) begin
      case (wf)
        `FCDMA_FIELD_MAR: rd_mux = {8'hff, mar[ws]};
        `FCDMA_FIELD_IOAR: rd_mux = {24'h0, ioar[ws]};
        `FCDMA_FIELD_COUNT: rd_mux = {16'h0, count[ws]};
        default: rd_mux = {24'h0, ctrl[ws]};
      endcase
    end else if (avs_address == `FCDMA_GLOBAL_ADDR) begin
      rd_mux = {20'h0, pair_full, 1'b0, (state != S_IDLE), pending, 3'h0, stop};
    end
  end

  // ==========================================================
  // Transfer engine and register file

  always @(posedge clock) begin
    if (reset) begin
      for (m = 0; m < 4; m = m + 1) begin
        mar[m] <= 24'h0;
        mar_init[m] <= 24'h0;
        ioar[m] <= 8'h0;
        count[m] <= 16'h0;
        ctrl[m] <= `FCDMA_CTRL_RESET;
      end
      stop <= 1'b0;
      pending <= 4'h0;
      state <= S_IDLE;
      cur <= 2'h0;
      cont <= 1'b0;
      ack <= 1'b0;
      avs_readdata <= 32'h0;
      xfer_end_n <= 2'h3;
      bus_request <= 1'b0;
      mem_address <= 24'h0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_word <= 1'b0;
      mem_write_data <= 16'h0;
    end else begin
      ack <= access & ~ack;
      if (avs_read & ~ack)
        avs_readdata <= rd_mux;
      pending <= ((pending & ~((start ? 4'h1 : 4'h0) << pick)) | set_pend) & en_mask;
      case (state)
        S_IDLE: begin
          if (start) begin
            cur <= pick;
            bus_request <= 1'b1;
            state <= S_REQ;
          end
        end
        S_REQ: begin
          if (bus_grant) begin
            mem_word <= word;
            mem_address <= src_addr;
            mem_read <= 1'b1;
            xfer_end_n[cur[1]] <= ~last;
            state <= S_READ;
          end
        end
        S_READ: begin
          if (mem_done) begin
            // write half follows on held bus
            mem_read <= 1'b0;
            mem_write <= 1'b1;
            mem_address <= dst_addr;
            mem_write_data <= mem_read_data;
            state <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (mem_done) begin
            mem_write <= 1'b0;
            xfer_end_n <= 2'h3;
            cont <= cur_full & ((block & ~blk_end) | (auto_burst & ~last));
            state <= S_NEXT;
            if (cur_full) begin
              if (~ctrl[ia][`FCDMA_CTRL_HOLD])
                mar[ia] <= step_addr(mar[ia], ctrl[ia][`FCDMA_CTRL_DOWN], word);
              if (~ctrl[ib][`FCDMA_CTRL_HOLD])
                mar[ib] <= step_addr(mar[ib], ctrl[ib][`FCDMA_CTRL_DOWN], word);
              if (block) begin
                if (blk_end) begin
                  count[ib][15:8] <= cntb[7:0];
                  count[ia] <= cnt - `FCDMA_COUNT_ONE;
                  if (ctrl[ia][`FCDMA_CTRL_FIX_DST])
                    mar[ib] <= mar_init[ib];
                  else
                    mar[ia] <= mar_init[ia];
                end else begin
                  count[ib][15:8] <= cntb[15:8] - `FCDMA_BYTE_ONE;
                end
              end else begin
                count[ia] <= cnt - `FCDMA_COUNT_ONE;
              end
              if (last)
                ctrl[ia][`FCDMA_CTRL_ENABLE] <= 1'b0;
            end else begin
              case (mode)
                `FCDMA_MODE_REPEAT: begin
                  if (last) begin
                    count[cur][15:8] <= cnt[7:0];
                    mar[cur] <= mar_init[cur];
                  end else begin
                    count[cur][15:8] <= cnt[15:8] - `FCDMA_BYTE_ONE;
                    mar[cur] <= step_addr(mar[cur], ctrl[cur][`FCDMA_CTRL_DOWN], word);
                  end
                end
                `FCDMA_MODE_IDLE: begin
                  count[cur] <= cnt - `FCDMA_COUNT_ONE;
                  if (last)
                    ctrl[cur][`FCDMA_CTRL_ENABLE] <= 1'b0;
                end
                default: begin
                  mar[cur] <= step_addr(mar[cur], ctrl[cur][`FCDMA_CTRL_DOWN], word);
                  count[cur] <= cnt - `FCDMA_COUNT_ONE;
                  if (last)
                    ctrl[cur][`FCDMA_CTRL_ENABLE] <= 1'b0;
                end
              endcase
            end
          end
        end
        S_NEXT: begin
          if (cont & ~stop) begin
            mem_word <= word;
            mem_address <= src_addr;
            mem_read <= 1'b1;
            xfer_end_n[cur[1]] <= ~last;
            state <= S_READ;
          end else begin
            bus_request <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          bus_request <= 1'b0;
          state <= S_IDLE;
        end
      endcase
      if (wr_en) begin
        case (wf)
          `FCDMA_FIELD_MAR: begin
            mar[ws] <= mar_merged[23:0];
            mar_init[ws] <= mar_merged[23:0];
          end
          `FCDMA_FIELD_IOAR: ioar[ws] <= avs_byteenable[0] ? avs_writedata[7:0] : ioar[ws];
          `FCDMA_FIELD_COUNT: count[ws] <= count_merged[15:0];
          default: ctrl[ws] <= avs_byteenable[0] ? avs_writedata[7:0] : ctrl[ws];
        endcase
      end
      if (avs_write & ack & (avs_address == `FCDMA_GLOBAL_ADDR) & avs_byteenable[0])
        stop <= avs_writedata[`FCDMA_GLOBAL_STOP];
    end
  end

endmodule

// File: fcdma_controller_properties.sv
// Port checker for the four-channel transfer unit.
// Assumes a bind to fcdma_controller and a single clock domain.
`timescale 1ns/1ps
module fcdma_checker (
  input wire clock,
  input wire reset,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [1:0] xfer_end_n,
  input wire bus_request,
  input wire bus_grant,
  input wire [23:0] mem_address,
  input wire mem_read,
  input wire mem_write,
  input wire mem_done
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // ==========
  // Register bus and memory master relations
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered after one wait");
  read_held_a: assert property (mem_read && !mem_done |=> mem_read && $stable(mem_address))
    else $error("read dropped or moved before done");
  write_follows_a: assert property (mem_read && mem_done |=> mem_write && !mem_read)
    else $error("write half did not follow read half");
  bus_held_a: assert property ((mem_read || mem_write) |-> bus_request)
    else $error("memory access without bus request");
  one_dir_a: assert property (!(mem_read && mem_write))
    else $error("read and write together");
  end_in_xfer_a: assert property (xfer_end_n != 2'b11 |-> mem_read || mem_write)
    else $error("transfer end outside a transfer");
  end_one_pair_a: assert property (xfer_end_n != 2'b00)
    else $error("both transfer end outputs low");
  grant_first_a: assert property ($rose(mem_read) |-> $past(bus_grant))
    else $error("read started without grant");
  write_ends_a: assert property (mem_write && mem_done |=> !mem_write && !mem_read)
    else $error("no gap after write half");
  cover property (mem_write && mem_done && xfer_end_n != 2'b11);
  cover property ($fell(bus_request));
  cover property (avs_write && !avs_waitrequest);
endmodule
bind fcdma_controller fcdma_checker i_fcdma_checker (.clock(clock), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .xfer_end_n(xfer_end_n),
  .bus_request(bus_request), .bus_grant(bus_grant), .mem_address(mem_address), .mem_read(mem_read),
  .mem_write(mem_write), .mem_done(mem_done));

// File: fcdma_mem_model.sv
// Arbiter and memory model at the transfer unit's master side.
// Assumes the unit holds each access until mem_done; logs the last 16 transfers.
`timescale 1ns/1ps
module fcdma_mem_model (
  input wire clock,
  input wire reset,
  input wire slow,
  input wire bus_request,
  output reg bus_grant,
  input wire [23:0] mem_address,
  input wire mem_read,
  input wire mem_write,
  input wire [15:0] mem_write_data,
  output wire [15:0] mem_read_data,
  output reg mem_done,
  input wire [1:0] xfer_end_n
);
  reg [23:0] rd_addr [0:15];
  reg [23:0] wr_addr [0:15];
  reg [15:0] wr_data [0:15];
  reg [1:0] end_seen [0:15];
  integer n_xfer = 0;
  integer n_req = 0;
  reg [2:0] wait_cnt = 3'h0;
  reg [15:0] last_data = 16'h0000;
  reg req_q = 1'b0;
  // Data lines show a changing pattern when no read is being answered.
  assign mem_read_data = (mem_read && mem_done) ? {mem_address[7:0], ~mem_address[7:0]} : ~last_data;
  always @(posedge clock) begin
    bus_grant <= bus_request && !reset;
    req_q <= bus_request;
    last_data <= mem_read_data;
    if (bus_request && !req_q)
      n_req <= n_req + 1;
    mem_done <= 1'b0;
    wait_cnt <= 3'h0;
    if ((mem_read || mem_write) && !mem_done) begin
      wait_cnt <= wait_cnt + 3'h1;
      if (wait_cnt == (slow ? 3'h3 : 3'h0))
        mem_done <= 1'b1;
    end
    if (mem_read && mem_done) begin
      rd_addr[n_xfer[3:0]] <= mem_address;
      end_seen[n_xfer[3:0]] <= xfer_end_n;
    end
    if (mem_write && mem_done) begin
      wr_addr[n_xfer[3:0]] <= mem_address;
      wr_data[n_xfer[3:0]] <= mem_write_data;
      n_xfer <= n_xfer + 1;
    end
  end
endmodule

// File: tb_fcdma_controller.sv
// Self-checking bench for the four-channel transfer unit.
// Assumes fcdma_controller, its checker and fcdma_mem_model are compiled first.
`timescale 1ns/1ps
module tb_fcdma_controller;
  typedef struct {logic [6:0] a; bit w; logic [31:0] d; logic [31:0] e;} fcdma_row_t;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [6:0] avs_address = 7'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [5:0] ev = 6'h00;
  reg [1:0] ext_n = 2'h3;
  reg mem_slow = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, bus_request, bus_grant, mem_read, mem_write, mem_word, mem_done;
  wire [1:0] xfer_end_n;
  wire [23:0] mem_address;
  wire [15:0] mem_write_data, mem_read_data;
  integer err_count = 0;
  integer n_tests = 0;
  integer cycles = 0;
  integer i;
  reg [31:0] rdata;
  fcdma_row_t rows [0:7];
  always #2.5 clock = ~clock;
  fcdma_controller i_fcdma_controller (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_match_a(ev[2:0]),
    .serial_tx_empty(ev[3]), .serial_rx_full(ev[4]), .adc_conversion_end(ev[5]), .ext_xfer_request_n(ext_n),
    .xfer_end_n(xfer_end_n), .bus_request(bus_request), .bus_grant(bus_grant), .mem_address(mem_address),
    .mem_read(mem_read), .mem_write(mem_write), .mem_word(mem_word), .mem_write_data(mem_write_data),
    .mem_read_data(mem_read_data), .mem_done(mem_done));
  fcdma_mem_model i_fcdma_mem_model (.clock(clock), .reset(reset), .slow(mem_slow), .bus_request(bus_request),
    .bus_grant(bus_grant), .mem_address(mem_address), .mem_read(mem_read), .mem_write(mem_write),
    .mem_write_data(mem_write_data), .mem_read_data(mem_read_data), .mem_done(mem_done),
    .xfer_end_n(xfer_end_n));
  // ==========
  // Shared tasks
  task check(input [31:0] got, input [31:0] exp, input string what);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: %0s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task acc(input bit w, input [6:0] a, input [31:0] d);
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd_chk(input [6:0] a, input [31:0] e);
    acc(1'b0, a, 32'h0);
    check(rdata, e, "register read");
  endtask
  task fire(input [5:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 6'h00;
  endtask
  task expect_n(input integer n);
    repeat (300)
      if (i_fcdma_mem_model.n_xfer < n) @(posedge clock);
    check(i_fcdma_mem_model.n_xfer, n, "transfer count");
  endtask
  task xf(input integer k, input [23:0] r, input [23:0] w, input [1:0] e);
    check(i_fcdma_mem_model.rd_addr[k], r, "source address");
    check(i_fcdma_mem_model.wr_addr[k], w, "destination address");
    check(i_fcdma_mem_model.end_seen[k], e, "transfer end");
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: timeout", $time);
      end_of_test;
    end
  end
  // ==========
  // Main sequence
  initial begin
    rows[0] = '{7'h0c, 0, 32'h0, 32'h0};
    rows[1] = '{7'h3c, 0, 32'h0, 32'h0};
    rows[2] = '{7'h00, 1, 32'h00abcdef, 32'hffabcdef};
    rows[3] = '{7'h04, 1, 32'h00001234, 32'h00000034};
    rows[4] = '{7'h08, 1, 32'h0000beef, 32'h0000beef};
    rows[5] = '{7'h44, 1, 32'h12345678, 32'h0};
    rows[6] = '{7'h7c, 0, 32'h0, 32'h0};
    rows[7] = '{7'h40, 0, 32'h0, 32'h0};
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (rows[i].w)
        acc(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("register table done");
    acc(1, 7'h00, 32'h001000); acc(1, 7'h04, 32'h20); acc(1, 7'h08, 32'h2); acc(1, 7'h0c, 32'h80);
    fire(6'h01); expect_n(1); fire(6'h01); expect_n(2);
    xf(0, 24'h001000, 24'hffff20, 2'b11); xf(1, 24'h001001, 24'hffff20, 2'b10);
    rd_chk(7'h0c, 32'h0); rd_chk(7'h00, 32'hff001002); rd_chk(7'h08, 32'h0);
    $display("io mode done");
    acc(1, 7'h10, 32'h002000); acc(1, 7'h14, 32'h30); acc(1, 7'h18, 32'h1); acc(1, 7'h1c, 32'hcc);
    fire(6'h10); expect_n(3); xf(2, 24'hffff30, 24'h002000, 2'b10);
    check(i_fcdma_mem_model.wr_data[2], 32'h30cf, "word data");
    rd_chk(7'h10, 32'hff002000);
    $display("idle mode done");
    mem_slow <= 1'b1;
    acc(1, 7'h20, 32'h003010); acc(1, 7'h24, 32'h40); acc(1, 7'h28, 32'h0202); acc(1, 7'h2c, 32'hb5);
    for (i = 0; i < 3; i = i + 1) begin
      fire(6'h20);
      expect_n(4 + i);
    end
    xf(3, 24'hffff40, 24'h003010, 2'b11); xf(4, 24'hffff40, 24'h00300f, 2'b01);
    xf(5, 24'hffff40, 24'h003010, 2'b11);
    rd_chk(7'h2c, 32'hb5); rd_chk(7'h28, 32'h0102);
    acc(1, 7'h2c, 32'h0);
    mem_slow <= 1'b0;
    $display("repeat mode done");
    acc(1, 7'h30, 32'h004000); acc(1, 7'h34, 32'h50); acc(1, 7'h38, 32'h1); acc(1, 7'h3c, 32'h86);
    @(posedge clock); ext_n <= 2'b10; repeat (10) @(posedge clock); ext_n <= 2'b11; repeat (30) @(posedge clock);
    check(i_fcdma_mem_model.n_xfer, 6, "idle pair moved");
    @(posedge clock); ext_n <= 2'b01; repeat (10) @(posedge clock); ext_n <= 2'b11;
    expect_n(7); xf(6, 24'h004000, 24'hffff50, 2'b01);
    $display("external request done");
    acc(1, 7'h1c, 32'h0); acc(1, 7'h00, 32'h005000); acc(1, 7'h10, 32'h006000); acc(1, 7'h08, 32'h3);
    i = i_fcdma_mem_model.n_req;
    acc(1, 7'h0c, 32'h86); expect_n(10);
    xf(7, 24'h005000, 24'h006000, 2'b11); xf(8, 24'h005001, 24'h006001, 2'b11);
    xf(9, 24'h005002, 24'h006002, 2'b10);
    check(i_fcdma_mem_model.n_req - i, 1, "burst requests");
    rd_chk(7'h0c, 32'h06);
    $display("full burst done");
    acc(1, 7'h0c, 32'h0); acc(1, 7'h40, 32'h1); acc(1, 7'h08, 32'h1); acc(1, 7'h0c, 32'h81);
    fire(6'h02); repeat (40) @(posedge clock);
    check(i_fcdma_mem_model.n_xfer, 10, "stopped unit moved");
    acc(1, 7'h40, 32'h0); fire(6'h02); expect_n(11); xf(10, 24'h005003, 24'hffff20, 2'b10);
    $display("stop done");
    acc(1, 7'h20, 32'h007000); acc(1, 7'h30, 32'h008000); acc(1, 7'h28, 32'h1); acc(1, 7'h38, 32'h0202);
    acc(1, 7'h3c, 32'h04); acc(1, 7'h2c, 32'h8e);
    fire(6'h01); expect_n(13);
    xf(11, 24'h007000, 24'h008000, 2'b11); xf(12, 24'h007001, 24'h008001, 2'b01);
    rd_chk(7'h30, 32'hff008000);
    rd_chk(7'h20, 32'hff007002);
    $display("block mode done");
    end_of_test;
  end
endmodule
